/* hdl/usbg_pkg.sv */
// Constants and register map of the USB general control register group
// Overview of operation
// - Clearing enable stops core, transceiver, USB clocks
// - Disable overrides freeze; freeze bit value kept
// - Disabled: status held at reset, status alias writes ignored
// - Enable bit writable while clock is frozen
// - Freeze bit gates USB clocks; clearing restores
// - Resume detection stays active while clocks frozen
// - Frozen: status read-only to software; hardware events still update it
// - Freeze bit writable while controller disabled
// - Clock-usable bit follows generic clock usability
// - Speed field: 00 full, 10 low speed
// - Status-clear alias: one clears matching bit
// - Status-set alias: one sets matching bit
// - Set and clear aliases read as zero
// - Version register: 12-bit version, reserved variant
// - Features register reports implemented endpoint count
// - Address-size register reports register window size
package usbg_pkg;

    localparam int ADDR_W = 12;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_GENERAL_CONTROL = 12'h800;
    localparam logic [ADDR_W-1:0] OFS_GENERAL_STATUS = 12'h804;
    localparam logic [ADDR_W-1:0] OFS_GENERAL_STATUS_CLEAR = 12'h808;
    localparam logic [ADDR_W-1:0] OFS_GENERAL_STATUS_SET = 12'h80c;
    localparam logic [ADDR_W-1:0] OFS_MODULE_VERSION = 12'h818;
    localparam logic [ADDR_W-1:0] OFS_MODULE_FEATURES = 12'h81c;
    localparam logic [ADDR_W-1:0] OFS_BUS_WINDOW_SIZE = 12'h820;

    // Field positions
    localparam int BIT_CONTROLLER_ENABLE = 15;
    localparam int BIT_CLOCK_FREEZE = 14;
    localparam int BIT_GENERIC_CLOCK_OK = 14;
    localparam int BIT_SPEED_LO = 12;
    localparam int STA_LO = 12;
    localparam int STA_HI = 14;

    // Reset values
    localparam logic [31:0] RST_GENERAL_CONTROL = 32'h0000_4000;
    localparam logic [31:0] RST_GENERAL_STATUS = 32'h0000_0000;
    localparam logic RST_CONTROLLER_ENABLE = RST_GENERAL_CONTROL[BIT_CONTROLLER_ENABLE];
    localparam logic RST_CLOCK_FREEZE = RST_GENERAL_CONTROL[BIT_CLOCK_FREEZE];
    localparam logic [STA_HI:STA_LO] RST_STA = RST_GENERAL_STATUS[STA_HI:STA_LO];

    // Speed codes
    localparam logic [1:0] SPEED_FULL = 2'h0;
    localparam logic [1:0] SPEED_LOW = 2'h2;

    // Identity and size values; version and variant values are arbitrary
    localparam logic [11:0] MODULE_VERSION_NUM = 12'h100;
    localparam logic [3:0] MODULE_VARIANT_NUM = 4'h0;
    localparam logic [3:0] ENDPOINT_COUNT = 4'h8;
    localparam logic [31:0] BUS_WINDOW_BYTES = 32'h0000_1000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Synchroniser reset value
    localparam logic SYNC_RST = 1'b0;

endpackage

/* hdl/usbg_sync_if.sv */
// Carrier between the top module and its pin synchroniser
`timescale 1ns/1ns
`default_nettype none
interface usbg_sync_if;
    logic raw;
    logic stable;
    logic changed;
    modport src (output raw, input stable, input changed);
    modport sync (input raw, output stable, output changed);
endinterface
`default_nettype wire

/* hdl/usbg_sync3.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module usbg_sync3
    import usbg_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Carrier
    usbg_sync_if.sync sif
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic stable_r;
    logic changed_r;
    wire agree = (s2_r == s3_r);

    // The first stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= SYNC_RST;
            s2_r <= SYNC_RST;
            s3_r <= SYNC_RST;
            stable_r <= SYNC_RST;
            changed_r <= 1'b0;
        end else begin
            s1_r <= sif.raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            changed_r <= agree && (s3_r != stable_r);
            if (agree) begin
                stable_r <= s3_r;
            end
        end
    end

    assign sif.stable = stable_r;
    assign sif.changed = changed_r;
endmodule
`default_nettype wire

/* hdl/usbg_regs.sv */
// USB general control and status registers behind an AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
module usbg_regs
    import usbg_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Status sources
    input wire logic generic_clock_ok_pin,
    input wire logic low_speed_mode,
    // Controls to the controller core
    output logic core_enable,
    output logic transceiver_enable,
    output logic usb_clock_enable,
    output logic resume_detect_enable,
    output logic regs_reset_hold,
    output logic regs_write_lock
);
    // Bus state
    logic awready_r;
    logic wready_r;
    logic aw_have_r;
    logic w_have_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // Block state
    logic ctl_en_r;
    logic ctl_frz_r;
    logic [STA_HI:STA_LO] sta_r;
    logic [STA_HI:STA_LO] sta_nxt;
    logic ls_prev_r;
    logic en_prev_r;
    logic core_en_r;
    logic xcvr_en_r;
    logic clk_en_r;
    logic resume_en_r;
    logic hold_r;
    logic lock_r;

    usbg_sync_if gclk_if ();
    assign gclk_if.raw = generic_clock_ok_pin;

    usbg_sync3 u_gclk_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .sif(gclk_if)
    );

    // Write and read channel handshakes
    wire aw_take = s_axi_awvalid && awready_r;
    wire w_take = s_axi_wvalid && wready_r;
    wire wr_fire = aw_have_r && w_have_r && !bvalid_r;
    wire b_done = bvalid_r && s_axi_bready;
    wire ar_take = s_axi_arvalid && arready_r;
    wire r_done = rvalid_r && s_axi_rready;

    // Write address decode
    wire wr_ctl = wr_fire && (awaddr_r == OFS_GENERAL_CONTROL);
    wire wr_clr = wr_fire && (awaddr_r == OFS_GENERAL_STATUS_CLEAR);
    wire wr_set = wr_fire && (awaddr_r == OFS_GENERAL_STATUS_SET);
    wire wr_hit = (awaddr_r == OFS_GENERAL_CONTROL) || (awaddr_r == OFS_GENERAL_STATUS)
        || (awaddr_r == OFS_GENERAL_STATUS_CLEAR) || (awaddr_r == OFS_GENERAL_STATUS_SET)
        || (awaddr_r == OFS_MODULE_VERSION) || (awaddr_r == OFS_MODULE_FEATURES)
        || (awaddr_r == OFS_BUS_WINDOW_SIZE);

    // Control bits live in byte lane 1; both stay writable in every mode
    wire ctl_lane = wstrb_r[1];
    wire en_nxt = (wr_ctl && ctl_lane) ? wdata_r[BIT_CONTROLLER_ENABLE] : ctl_en_r;
    wire frz_nxt = (wr_ctl && ctl_lane) ? wdata_r[BIT_CLOCK_FREEZE] : ctl_frz_r;

    // Hardware view of the status field
    wire [1:0] speed_hw = low_speed_mode ? SPEED_LOW : SPEED_FULL;
    wire [STA_HI:STA_LO] sta_hw = {gclk_if.stable, speed_hw};
    wire en_rise = ctl_en_r && !en_prev_r;
    wire gclk_evt = gclk_if.changed || en_rise;
    wire spd_evt = (low_speed_mode != ls_prev_r) || en_rise;
    wire [STA_HI:STA_LO] hw_evt = {gclk_evt, spd_evt, spd_evt};
    // Software may touch the status only while running and unfrozen
    wire sw_ok = ctl_en_r && !ctl_frz_r;
    wire [STA_HI:STA_LO] clr_mask = (wr_clr && sw_ok && wstrb_r[1]) ? wdata_r[STA_HI:STA_LO]
        : '0;
    wire [STA_HI:STA_LO] set_mask = (wr_set && sw_ok && wstrb_r[1]) ? wdata_r[STA_HI:STA_LO]
        : '0;

    // Per bit: hardware event wins over software, set wins over clear
    genvar gi;
    generate
        for (gi = STA_LO; gi <= STA_HI; gi++) begin : g_sta
            assign sta_nxt[gi] = !ctl_en_r ? RST_STA[gi]
                : hw_evt[gi] ? sta_hw[gi]
                : set_mask[gi] ? 1'b1
                : clr_mask[gi] ? 1'b0
                : sta_r[gi];
        end
    endgenerate

    // Read data decode
    wire [31:0] rd_ctl = 32'({ctl_en_r, ctl_frz_r}) << BIT_CLOCK_FREEZE;
    wire [31:0] rd_sta = 32'(sta_r) << STA_LO;
    wire [31:0] rd_ver = {12'h000, MODULE_VARIANT_NUM, 4'h0, MODULE_VERSION_NUM};
    wire [31:0] rd_feat = {28'h0000000, ENDPOINT_COUNT};
    wire rd_is_ctl = (s_axi_araddr == OFS_GENERAL_CONTROL);
    wire rd_is_sta = (s_axi_araddr == OFS_GENERAL_STATUS);
    wire rd_is_alias = (s_axi_araddr == OFS_GENERAL_STATUS_CLEAR)
        || (s_axi_araddr == OFS_GENERAL_STATUS_SET);
    wire rd_is_ver = (s_axi_araddr == OFS_MODULE_VERSION);
    wire rd_is_feat = (s_axi_araddr == OFS_MODULE_FEATURES);
    wire rd_is_win = (s_axi_araddr == OFS_BUS_WINDOW_SIZE);
    wire rd_hit = rd_is_ctl || rd_is_sta || rd_is_alias || rd_is_ver || rd_is_feat || rd_is_win;
    wire [31:0] rd_mux = rd_is_ctl ? rd_ctl
        : rd_is_sta ? rd_sta
        : rd_is_ver ? rd_ver
        : rd_is_feat ? rd_feat
        : rd_is_win ? BUS_WINDOW_BYTES
        : 32'h0000_0000;

    // Write path: address and data accepted in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (aw_take) begin
                aw_have_r <= 1'b1;
                awready_r <= 1'b0;
                awaddr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
            end
            if (w_take) begin
                w_have_r <= 1'b1;
                wready_r <= 1'b0;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_done) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // Read path: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (r_done) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // Control and status registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_en_r <= RST_CONTROLLER_ENABLE;
            ctl_frz_r <= RST_CLOCK_FREEZE;
            sta_r <= RST_STA;
            ls_prev_r <= 1'b0;
            en_prev_r <= RST_CONTROLLER_ENABLE;
        end else begin
            ctl_en_r <= en_nxt;
            ctl_frz_r <= frz_nxt;
            sta_r <= sta_nxt;
            ls_prev_r <= low_speed_mode;
            en_prev_r <= ctl_en_r;
        end
    end

    // Derived controls; clock gating follows the stored bits a cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_en_r <= 1'b0;
            xcvr_en_r <= 1'b0;
            clk_en_r <= 1'b0;
            resume_en_r <= 1'b0;
            hold_r <= 1'b1;
            lock_r <= 1'b1;
        end else begin
            core_en_r <= ctl_en_r;
            xcvr_en_r <= ctl_en_r;
            clk_en_r <= ctl_en_r && !ctl_frz_r;
            resume_en_r <= ctl_en_r;
            hold_r <= !ctl_en_r;
            lock_r <= !ctl_en_r || ctl_frz_r;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign core_enable = core_en_r;
    assign transceiver_enable = xcvr_en_r;
    assign usb_clock_enable = clk_en_r;
    assign resume_detect_enable = resume_en_r;
    assign regs_reset_hold = hold_r;
    assign regs_write_lock = lock_r;

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_disable_stops_all: assert property (
        !ctl_en_r |=> !core_enable && !transceiver_enable && !usb_clock_enable)
        else $error("disabled controller still drives core or clocks");

    a_disable_keeps_frz: assert property (
        (!ctl_en_r && !(wr_ctl && ctl_lane)) |=> ctl_frz_r == $past(ctl_frz_r)
            && !usb_clock_enable)
        else $error("disable altered the freeze bit or let clocks run");

    a_disabled_sta_reset: assert property (
        !ctl_en_r ##1 !ctl_en_r |-> sta_r == RST_STA && regs_reset_hold)
        else $error("status not held at reset while disabled");

    a_en_write_frozen: assert property (
        (wr_ctl && ctl_lane && ctl_frz_r) |=> ctl_en_r == $past(wdata_r[BIT_CONTROLLER_ENABLE]))
        else $error("enable write lost while frozen");

    a_freeze_gates_clk: assert property (
        (ctl_en_r && !ctl_frz_r) ##1 (ctl_en_r && ctl_frz_r) |=> !usb_clock_enable)
        else $error("freeze did not gate the USB clocks");

    a_resume_while_frozen: assert property (
        (ctl_en_r && ctl_frz_r)[*2] |-> resume_detect_enable && !usb_clock_enable)
        else $error("resume detection lost while frozen");

    a_frozen_sta_kept: assert property (
        (ctl_en_r && ctl_frz_r && (wr_set || wr_clr) && hw_evt == '0 && !en_rise)
            |=> $stable(sta_r))
        else $error("status changed by software while frozen");

    a_frz_write_disabled: assert property (
        (wr_ctl && ctl_lane && !ctl_en_r) |=> ctl_frz_r == $past(wdata_r[BIT_CLOCK_FREEZE]))
        else $error("freeze write lost while disabled");

    a_speed_code: assert property (
        (ctl_en_r && spd_evt) |=> sta_r[STA_LO+1:STA_LO] == ($past(low_speed_mode)
            ? SPEED_LOW : SPEED_FULL))
        else $error("speed field wrong after speed change");

    a_set_alias: assert property (
        (wr_set && sw_ok && wstrb_r[1] && wdata_r[BIT_GENERIC_CLOCK_OK] && !gclk_evt)
            |=> sta_r[BIT_GENERIC_CLOCK_OK])
        else $error("set alias did not set status bit");

    a_clr_alias: assert property (
        (wr_clr && sw_ok && wstrb_r[1] && wdata_r[BIT_GENERIC_CLOCK_OK] && !gclk_evt)
            |=> !sta_r[BIT_GENERIC_CLOCK_OK])
        else $error("clear alias did not clear status bit");

    a_alias_reads_zero: assert property (
        (ar_take && rd_is_alias) |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
        else $error("set or clear alias read nonzero");

    a_write_answer: assert property (
        wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response missing or channels reopened early");

    a_clock_ok_reload: assert property (
        (ctl_en_r && gclk_evt) |=> sta_r[BIT_GENERIC_CLOCK_OK] == $past(gclk_if.stable))
        else $error("clock-usable bit did not follow the synchronised pin");

    a_version_read: assert property (
        (ar_take && rd_is_ver) |=> s_axi_rdata[11:0] == MODULE_VERSION_NUM
            && s_axi_rdata[31:20] == 12'h000)
        else $error("version register read wrong");

    a_features_read: assert property (
        (ar_take && rd_is_feat) |=> s_axi_rdata[3:0] == ENDPOINT_COUNT
            && s_axi_rdata[31:4] == 28'h0000000)
        else $error("features register read wrong");

    a_window_read: assert property (
        (ar_take && rd_is_win) |=> s_axi_rdata == BUS_WINDOW_BYTES)
        else $error("address-size register read wrong");

    a_unmapped_write: assert property (
        (wr_fire && !wr_hit) |=> s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");

    c_write_control: cover property (wr_ctl ##1 s_axi_bvalid && s_axi_bready);
    c_enable_unfreeze: cover property (ctl_en_r && ctl_frz_r ##[1:50] ctl_en_r && !ctl_frz_r);
    c_read_status: cover property (ar_take && rd_is_sta ##1 r_done);
    c_gclk_event: cover property (ctl_en_r && gclk_if.changed);

endmodule
`default_nettype wire

/* test/usb_general_control_regs_test.sv */
// Self-checking bench for the USB general control register group
`timescale 1ns/1ns
`default_nettype none
module usb_general_control_regs_test
    import usbg_pkg::*;
;
    localparam logic [ADDR_W-1:0] OFS_UNMAPPED = 12'h810;
    localparam logic [31:0] CTL_EN = 32'h0000_8000;
    localparam logic [31:0] CTL_FRZ = 32'h0000_4000;
    // Control outputs as {core, xcvr, usb clock, resume, reset hold, write lock}
    localparam logic [31:0] OUT_OFF = 32'h03;
    localparam logic [31:0] OUT_RUN = 32'h3c;
    localparam logic [31:0] OUT_FROZEN = 32'h35;
    localparam logic [31:0] EXP_VER = {12'h000, MODULE_VARIANT_NUM, 4'h0, MODULE_VERSION_NUM};

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic generic_clock_ok_pin = 1'b0;
    logic low_speed_mode = 1'b0;
    logic core_enable;
    logic transceiver_enable;
    logic usb_clock_enable;
    logic resume_detect_enable;
    logic regs_reset_hold;
    logic regs_write_lock;
    int error_cnt = 0;
    int num_checks = 0;

    wire [5:0] ctl_outs = {core_enable, transceiver_enable, usb_clock_enable,
                           resume_detect_enable, regs_reset_hold, regs_write_lock};

    always #4 aclk = ~aclk;

    usbg_regs uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .generic_clock_ok_pin(generic_clock_ok_pin), .low_speed_mode(low_speed_mode),
        .core_enable(core_enable), .transceiver_enable(transceiver_enable),
        .usb_clock_enable(usb_clock_enable), .resume_detect_enable(resume_detect_enable),
        .regs_reset_hold(regs_reset_hold), .regs_write_lock(regs_write_lock)
    );

    task automatic conclude();
        $display("Mismatches %0d in %0d comparisons", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Outputs are sampled in the active region, so they hold their pre-edge values
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] rsp);
        int n;
        logic aw_pend;
        logic w_pend;
        logic done;
        n = 0;
        aw_pend = 1'b1;
        w_pend = 1'b1;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done && n < 50) begin
            @(posedge aclk);
            n++;
            if (!aw_pend && !w_pend && s_axi_bvalid === 1'b1) begin
                done = 1'b1;
                s_axi_bready <= 1'b0;
                chk({30'h0, s_axi_bresp}, {30'h0, rsp}, "write response");
            end
            if (aw_pend && s_axi_awready === 1'b1) begin
                aw_pend = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_pend && s_axi_wready === 1'b1) begin
                w_pend = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        if (!done) begin
            chk(32'h0, 32'h1, "write handshake timeout");
        end
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] rsp);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done && n < 50) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
            end else if (!s_axi_arvalid && s_axi_rvalid === 1'b1) begin
                done = 1'b1;
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata, exp, "read data");
                chk({30'h0, s_axi_rresp}, {30'h0, rsp}, "read response");
            end
        end
        if (!done) begin
            chk(32'h0, 32'h1, "read handshake timeout");
        end
    endtask

    task automatic outs(input logic [31:0] exp);
        repeat (3) @(posedge aclk);
        chk({26'h0, ctl_outs}, exp, "control outputs");
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_GENERAL_CONTROL, RST_GENERAL_CONTROL, RESP_OKAY);
        outs(OUT_OFF);
        generic_clock_ok_pin <= 1'b1;
        low_speed_mode <= 1'b1;
        // Disabled: status stays at reset and the set alias is ignored
        wr(OFS_GENERAL_STATUS_SET, 32'h0000_6000, RESP_OKAY);
        repeat (10) @(posedge aclk);
        rd(OFS_GENERAL_STATUS, 32'h0, RESP_OKAY);
        wr(OFS_GENERAL_CONTROL, 32'h0, RESP_OKAY);
        rd(OFS_GENERAL_CONTROL, 32'h0, RESP_OKAY);
        outs(OUT_OFF);
        wr(OFS_GENERAL_CONTROL, CTL_EN, RESP_OKAY);
        outs(OUT_RUN);
        rd(OFS_GENERAL_STATUS, 32'h0000_6000, RESP_OKAY);
        low_speed_mode <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(OFS_GENERAL_STATUS, 32'h0000_4000, RESP_OKAY);
        wr(OFS_GENERAL_STATUS_CLEAR, 32'h0000_4000, RESP_OKAY);
        rd(OFS_GENERAL_STATUS, 32'h0, RESP_OKAY);
        wr(OFS_GENERAL_STATUS_SET, 32'h0000_2000, RESP_OKAY);
        rd(OFS_GENERAL_STATUS, 32'h0000_2000, RESP_OKAY);
        wr(OFS_GENERAL_STATUS_SET, 32'h0, RESP_OKAY);
        wr(OFS_GENERAL_STATUS_CLEAR, 32'h0, RESP_OKAY);
        rd(OFS_GENERAL_STATUS, 32'h0000_2000, RESP_OKAY);
        rd(OFS_GENERAL_STATUS_CLEAR, 32'h0, RESP_OKAY);
        rd(OFS_GENERAL_STATUS_SET, 32'h0, RESP_OKAY);
        // Pin passes a synchroniser, so allow it time to land
        generic_clock_ok_pin <= 1'b0;
        repeat (10) @(posedge aclk);
        rd(OFS_GENERAL_STATUS, 32'h0000_2000, RESP_OKAY);
        generic_clock_ok_pin <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(OFS_GENERAL_STATUS, 32'h0000_6000, RESP_OKAY);
        wr(OFS_GENERAL_CONTROL, CTL_EN | CTL_FRZ, RESP_OKAY);
        outs(OUT_FROZEN);
        wr(OFS_GENERAL_STATUS_CLEAR, 32'h0000_6000, RESP_OKAY);
        rd(OFS_GENERAL_STATUS, 32'h0000_6000, RESP_OKAY);
        wr(OFS_GENERAL_CONTROL, CTL_EN, RESP_OKAY);
        outs(OUT_RUN);
        wr(OFS_GENERAL_STATUS_CLEAR, 32'h0000_6000, RESP_OKAY);
        rd(OFS_GENERAL_STATUS, 32'h0, RESP_OKAY);
        wr(OFS_GENERAL_CONTROL, CTL_EN | CTL_FRZ, RESP_OKAY);
        wr(OFS_GENERAL_CONTROL, CTL_FRZ, RESP_OKAY);
        rd(OFS_GENERAL_CONTROL, CTL_FRZ, RESP_OKAY);
        outs(OUT_OFF);
        rd(OFS_GENERAL_STATUS, 32'h0, RESP_OKAY);
        // Re-enabling reloads status from the live sources
        wr(OFS_GENERAL_CONTROL, CTL_EN, RESP_OKAY);
        repeat (3) @(posedge aclk);
        rd(OFS_GENERAL_STATUS, 32'h0000_4000, RESP_OKAY);
        // Control bits sit in byte lane 1, so a lane-0-only write must not touch them
        s_axi_wstrb <= 4'h1;
        wr(OFS_GENERAL_CONTROL, 32'h0, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(OFS_GENERAL_CONTROL, CTL_EN, RESP_OKAY);
        rd(OFS_MODULE_VERSION, EXP_VER, RESP_OKAY);
        wr(OFS_MODULE_VERSION, 32'hffff_ffff, RESP_OKAY);
        rd(OFS_MODULE_VERSION, EXP_VER, RESP_OKAY);
        rd(OFS_MODULE_FEATURES, {28'h0, ENDPOINT_COUNT}, RESP_OKAY);
        wr(OFS_BUS_WINDOW_SIZE, 32'h0, RESP_OKAY);
        rd(OFS_BUS_WINDOW_SIZE, BUS_WINDOW_BYTES, RESP_OKAY);
        wr(OFS_UNMAPPED, 32'hffff_ffff, RESP_SLVERR);
        rd(OFS_UNMAPPED, 32'h0, RESP_SLVERR);
        // Second reset in mid-run must restore the control word
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_GENERAL_CONTROL, RST_GENERAL_CONTROL, RESP_OKAY);
        outs(OUT_OFF);
        conclude();
    end
endmodule
`default_nettype wire
